// ### sph_dev.sv
// What this block does
// - pause floats output, ignores clock and data
// - host keeps select low while paused
// - deselect while paused abandons transfer
// - pause pin acts at once when clock low
// - pause pin waits for clock falling edge
// - low supply aborts pending writes
// - low supply clears write enable latch
// - host re-enables writes after supply recovery
// - writes start only when select goes high, never while selected
// - host keeps select high when idle
// - host never raises select and clock together
// - output drives high, low or floats
// - writes need write enable latch set
module sph_dev
  import sph_pkg::*;
(
  input  wire logic  clock,
  input  wire logic  rstn,
  sph_if.dev         link,
  input  wire logic  low_supply,
  output logic       write_enable_latch,
  output logic       write_start,
  output logic       status_write_start,
  output logic       paused,
  output logic [7:0] cmd_seen
);
  logic       cs_s;
  logic       sck_s;
  logic       si_s;
  logic       pz_s;
  logic       ls_s;
  logic       sck_d_reg;
  logic       sck_rise;
  logic       sck_fall;
  logic       active;
  logic       cmd_done;
  logic [7:0] byte_in;
  logic [7:0] status_word;
  logic [2:0] bit_reg;
  logic [7:0] shift_reg;
  logic       got_cmd_reg;
  logic       pend_wr_reg;
  logic       pend_sr_reg;
  logic [7:0] out_reg;
  logic       so_reg;

  // ----------------------------------------
  // synchronisers
  // ----------------------------------------
  // select and pause idle high, so they reset high
  sph_sync #(.INIT(1'b1)) u_cs (
    .clock(clock),
    .rstn (rstn),
    .d    (link.cs_n),
    .q    (cs_s)
  );
  sph_sync #(.INIT(1'b0)) u_ck (
    .clock(clock),
    .rstn (rstn),
    .d    (link.sck),
    .q    (sck_s)
  );
  sph_sync #(.INIT(1'b0)) u_si (
    .clock(clock),
    .rstn (rstn),
    .d    (link.si),
    .q    (si_s)
  );
  sph_sync #(.INIT(1'b1)) u_pz (
    .clock(clock),
    .rstn (rstn),
    .d    (link.pause_n),
    .q    (pz_s)
  );
  // detector output is asynchronous to this clock
  sph_sync #(.INIT(1'b0)) u_ls (
    .clock(clock),
    .rstn (rstn),
    .d    (low_supply),
    .q    (ls_s)
  );

  // ----------------------------------------
  // link clock edges
  // ----------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sck_d_reg <= 1'b0;
    end else begin
      sck_d_reg <= sck_s;
    end
  end
  assign sck_rise = sck_s & ~sck_d_reg;
  assign sck_fall = ~sck_s & sck_d_reg;

  // ----------------------------------------
  // pause state
  // ----------------------------------------
  // pin and clock share the same sync lag, so their order is kept
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      paused <= 1'b0;
    end else if (cs_s) begin
      paused <= 1'b0;
    end else if (!sck_s) begin
      paused <= ~pz_s;
    end
  end
  assign active = ~cs_s & ~paused;

  // ----------------------------------------
  // shifter
  // ----------------------------------------
  assign byte_in  = {shift_reg[6:0], si_s};
  assign cmd_done = active & sck_rise & (bit_reg == BIT_LAST) & ~got_cmd_reg;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bit_reg <= '0;
    end else if (cs_s) begin
      bit_reg <= '0;
    end else if (active && sck_rise) begin
      bit_reg <= bit_reg + 3'h1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      shift_reg <= '0;
    end else if (active && sck_rise) begin
      shift_reg <= byte_in;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      got_cmd_reg <= 1'b0;
    end else if (cs_s) begin
      got_cmd_reg <= 1'b0;
    end else if (cmd_done) begin
      got_cmd_reg <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cmd_seen <= '0;
    end else if (cmd_done) begin
      cmd_seen <= byte_in;
    end
  end

  // ----------------------------------------
  // latch and write control
  // ----------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      write_enable_latch <= 1'b0;
    end else if (ls_s) begin
      write_enable_latch <= 1'b0;
    // a started write uses up the latch
    end else if (cs_s && (pend_wr_reg || pend_sr_reg)) begin
      write_enable_latch <= 1'b0;
    end else if (cmd_done && byte_in == CMD_WREN) begin
      write_enable_latch <= 1'b1;
    end else if (cmd_done && byte_in == CMD_WRITE_DISABLE) begin
      write_enable_latch <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pend_wr_reg <= 1'b0;
    end else if (ls_s || cs_s) begin
      pend_wr_reg <= 1'b0;
    end else if (cmd_done && byte_in == CMD_WRITE) begin
      pend_wr_reg <= write_enable_latch;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pend_sr_reg <= 1'b0;
    end else if (ls_s || cs_s) begin
      pend_sr_reg <= 1'b0;
    end else if (cmd_done && byte_in == CMD_STATUS_WRITE) begin
      pend_sr_reg <= write_enable_latch;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      write_start <= 1'b0;
    end else begin
      write_start <= cs_s & ~ls_s & pend_wr_reg;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      status_write_start <= 1'b0;
    end else begin
      status_write_start <= cs_s & ~ls_s & pend_sr_reg;
    end
  end

  // ----------------------------------------
  // serial output
  // ----------------------------------------
  assign status_word = {7'h00, write_enable_latch} << STAT_LATCH_BIT;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      out_reg <= '0;
    end else if (cs_s) begin
      out_reg <= '0;
    end else if (cmd_done) begin
      out_reg <= (byte_in == CMD_RDSR) ? status_word : 8'h00;
    end else if (active && sck_fall && got_cmd_reg) begin
      out_reg <= {out_reg[6:0], out_reg[7]};
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      so_reg <= 1'b0;
    end else if (active && sck_fall && got_cmd_reg) begin
      so_reg <= out_reg[7];
    end
  end

  assign link.so_o  = so_reg;
  assign link.so_oe = active;
endmodule

// ### sph_pkg.sv
package sph_pkg;
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned LINK_DIV     = 8;
  localparam logic [7:0]  CMD_WREN     = 8'h06;
  localparam logic [7:0]  CMD_WRITE_DISABLE = 8'h04;
  localparam logic [7:0]  CMD_STATUS_WRITE  = 8'h01;
  localparam logic [7:0]  CMD_WRITE    = 8'h02;
  localparam logic [7:0]  CMD_RDSR     = 8'h05;
  localparam logic [2:0]  BIT_LAST     = 3'h7;
  localparam int unsigned STAT_LATCH_BIT = 1;
endpackage

// ### sph_if.sv
interface sph_if;
  logic cs_n;
  logic sck;
  logic si;
  logic pause_n;
  logic so_o;
  logic so_oe;
  wire  so_line = so_oe ? so_o : 1'b1;
  modport dev  (input cs_n, input sck, input si, input pause_n, output so_o, output so_oe);
  modport host (output cs_n, output sck, output si, output pause_n, input so_line);
endinterface

// ### sph_sync.sv
module sph_sync #(
  parameter logic INIT = 1'b0
) (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic d,
  output logic      q
);
  logic meta_reg;
  // first stage feeds only the second
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      // reset to INIT, the pin's idle level for every instance but u_so, whose so_line idles high while INIT stays 0
      meta_reg <= INIT;
      q        <= INIT;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule

// ### sph_host.sv
module sph_host
  import sph_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rstn,
  sph_if.host             link,
  input  wire logic       start,
  input  wire logic [7:0] tx_byte,
  input  wire logic       pause_req,
  output logic            busy,
  output logic [7:0]      rx_byte
);
  typedef enum logic [2:0] {
    SPH_IDLE = 3'b001,
    SPH_SHIFT = 3'b010,
    SPH_END = 3'b100
  } sph_state_e;
  sph_state_e st_reg;
  logic [3:0] div_reg;
  logic [2:0] bit_reg;
  logic [7:0] tx_reg;
  logic       so_s, sck_reg, cs_reg, pz_reg;

  sph_sync u_so (.clock(clock), .rstn(rstn), .d(link.so_line), .q(so_s));

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_reg  <= SPH_IDLE;
      div_reg <= '0;
      bit_reg <= '0;
      tx_reg  <= '0;
      sck_reg <= 1'b0;
      cs_reg  <= 1'b1;
      pz_reg  <= 1'b1;
      rx_byte <= '0;
    end else begin
      // pause only inside frame
      // release is always allowed, or a pause taken with clock high would hang
      if (st_reg != SPH_SHIFT) begin
        pz_reg <= 1'b1;
      end else if (!sck_reg || !pause_req) begin
        pz_reg <= ~pause_req;
      end
      unique case (st_reg)
        SPH_IDLE: if (start) begin
          cs_reg  <= 1'b0;
          tx_reg  <= tx_byte;
          bit_reg <= '0;
          div_reg <= '0;
          st_reg  <= SPH_SHIFT;
        end
        SPH_SHIFT: if (pz_reg) begin
          div_reg <= div_reg + 4'h1;
          if (div_reg == 4'(LINK_DIV - 1)) begin
            div_reg <= '0;
            sck_reg <= ~sck_reg;
            if (sck_reg) begin
              tx_reg  <= {tx_reg[6:0], 1'b0};
              bit_reg <= bit_reg + 3'h1;
              if (bit_reg == BIT_LAST) st_reg <= SPH_END;
            end else begin
              rx_byte <= {rx_byte[6:0], so_s};
            end
          end
        end
        SPH_END: begin
          cs_reg <= 1'b1;
          st_reg <= SPH_IDLE;
        end
        default: st_reg <= SPH_IDLE;
      endcase
    end
  end
  assign link.cs_n    = cs_reg;
  assign link.sck     = sck_reg;
  assign link.si      = tx_reg[7];
  assign link.pause_n = pz_reg;
  assign busy         = (st_reg != SPH_IDLE);
endmodule

// ### sph_link_asserts.sv
module sph_link_asserts (
  input wire logic clock,
  input wire logic rstn,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic pause_n,
  input wire logic so_oe,
  input wire logic low_supply,
  input wire logic write_enable_latch,
  input wire logic write_start,
  input wire logic status_write_start
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------
  // checks
  // ----------
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // sync lag of the pins is allowed for
  a_float_paused:
    assert property ((!pause_n && !sck) [*6] |-> !so_oe) else $error("so driven in pause");
  a_float_idle:
    assert property (cs_n [*6] |-> !so_oe) else $error("so driven while idle");
  a_pause_defer:
    assert property ($fell(pause_n) && sck && so_oe |=> so_oe) else $error("pause not deferred");
  a_select_held:
    assert property (!pause_n |-> !cs_n) else $error("deselected in pause");
  a_rise_clear:
    assert property ($rose(cs_n) |-> !sck && $past(!sck)) else $error("select rose with clock");
  a_low_no_write:
    assert property (low_supply [*4] |-> !write_start && !status_write_start)
      else $error("write under low supply");
  a_low_clear:
    assert property (low_supply [*4] |-> !write_enable_latch) else $error("latch kept");
  a_write_latch:
    assert property (write_start || status_write_start |-> $past(write_enable_latch))
      else $error("write without latch");
  a_idle_no_write:
    assert property (cs_n [*8] |-> !write_start) else $error("write while idle");
  cover property ($fell(pause_n));
  cover property (write_start);
  cover property ($fell(write_enable_latch));
endmodule

// ### testbench.sv
module testbench
  import sph_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clock, rstn, start, pause_req, low_supply, busy, wlatch, wr, swr;
  logic [7:0] tx_byte;
  logic [7:0] cmd_seen;
  int         fails, num_checks, seed, nw, ns, ew, es, ml;
  logic [7:0] cq[$] = '{8'h06, 8'h02, 8'h04, 8'h02, 8'h06, 8'h01, 8'h04, 8'h01, 8'h05};
  sph_if lnk();
  sph_dev sph_dev_i (.clock, .rstn, .link(lnk), .low_supply, .write_enable_latch(wlatch),
    .write_start(wr), .status_write_start(swr), .paused(), .cmd_seen);
  sph_host sph_host_i (.clock, .rstn, .link(lnk), .start, .tx_byte, .pause_req, .busy,
    .rx_byte());
  sph_link_asserts chk_i (.clock, .rstn, .cs_n(lnk.cs_n), .sck(lnk.sck),
    .pause_n(lnk.pause_n), .so_oe(lnk.so_oe), .low_supply, .write_enable_latch(wlatch),
    .write_start(wr), .status_write_start(swr));
  // ----------
  // helpers
  // ----------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // pause and low supply both land mid-byte
  task automatic step(input logic [7:0] b, input logic p, input logic ls);
    tx_byte <= b;
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    repeat (8 + ($random(seed) & 63)) @(posedge clock);
    pause_req <= p;
    low_supply <= ls;
    repeat (24) @(posedge clock);
    pause_req <= 1'b0;
    low_supply <= 1'b0;
    for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge clock);
    repeat (12) @(posedge clock);
    if (ls) ml = 0;
    if (b == CMD_WREN) ml = 1;
    if (b == CMD_WRITE_DISABLE) ml = 0;
    // a started write uses up the latch
    if (ml == 1 && b == CMD_WRITE) begin ew++; ml = 0; end
    if (ml == 1 && b == CMD_STATUS_WRITE) begin es++; ml = 0; end
    chk(cmd_seen, b);
    chk(8'(nw), 8'(ew));
    chk(8'(ns), 8'(es));
    chk({7'h00, wlatch}, 8'(ml));
    $display("test done cmd %h", b);
  endtask
  always @(posedge clock) begin
    if (wr === 1'b1) nw++;
    if (swr === 1'b1) ns++;
  end
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    give_verdict;
  end
  initial begin
    {rstn, start, pause_req, low_supply, tx_byte} = '0;
    seed = 72;
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    repeat (2) @(posedge clock);
    foreach (cq[k]) step(cq[k], 1'($random(seed)), 1'b0);
    step(CMD_WREN, 1'b0, 1'b0);
    step(CMD_WRITE, 1'b0, 1'b1);
    step(CMD_WRITE, 1'b0, 1'b0);
    step(CMD_WREN, 1'b1, 1'b0);
    step(CMD_STATUS_WRITE, 1'b1, 1'b0);
    give_verdict;
  end
endmodule
